// ===== logic/dcv_pkg.sv
// Shared types and constants for the double-precision convert block
package dcv_pkg;
    localparam int REG_AW       = 4;
    localparam int RF_DEPTH     = 10;
    localparam int HALF_W       = 32;
    localparam int DBL_W        = 64;
    localparam int DBL_BIAS     = 1023;
    localparam int SGL_BIAS     = 127;
    localparam logic [1:0] RST_HALVES = 2'h0;

    // Operation requested by the host
    typedef enum logic [1:0] {
        DCV_OP_TO_SINGLE  = 2'b00,
        DCV_OP_TO_INTEGER = 2'b01
    } dcv_op_t;

    // Where the double operand comes from
    typedef enum logic [1:0] {
        DCV_SRC_REG    = 2'b00,
        DCV_SRC_HOST   = 2'b01,
        DCV_SRC_MEMORY = 2'b10
    } dcv_src_t;

    // Instruction issued by the host
    typedef struct packed {
        dcv_op_t                 op;
        dcv_src_t                src;
        logic                    src_file_b;
        logic [REG_AW-1:0]       src_idx;
        logic                    dst_file_b;
        logic [REG_AW-1:0]       dst_idx;
    } dcv_cmd_t;

    // One 32-bit operand word from the host
    typedef struct packed {
        logic                    last;
        logic [HALF_W-1:0]       data;
    } dcv_word_t;

    typedef enum logic [1:0] {
        DCV_ST_IDLE    = 2'b00,
        DCV_ST_LOAD    = 2'b01,
        DCV_ST_CONVERT = 2'b10
    } dcv_state_t;
endpackage

// ===== logic/dcv_convert.sv
// Double-to-single and double-to-integer conversion datapath
//
// Contract
// - Two host words form the double in source register, then convert to single.
// - Source register is always from file A, never file B.
// - Memory-sourced double converts to single into destination register.
// - Register-only form converts held double to 32-bit integer.
// - Two host words form the double, then convert to 32-bit integer.
// - Memory-sourced double converts to integer into destination register.
// - Loaded double stays in the source register beside the result, unless the destination is that same file A register.
// - Register-only form converts held double to single into destination.
`timescale 1ns/1ps
`default_nettype none
module dcv_convert #(
    parameter int RF_DEPTH = dcv_pkg::RF_DEPTH
) (
    // Clock and reset
    input  wire logic                         i_clk,
    input  wire logic                         i_rst_b,
    // Instruction
    input  wire logic                         i_cmd_valid,
    input  wire dcv_pkg::dcv_cmd_t            i_cmd,
    output logic                              o_cmd_ready,
    // Operand words from host registers or memory
    input  wire logic                         i_word_valid,
    input  wire dcv_pkg::dcv_word_t           i_word,
    output logic                              o_word_ready,
    // Completion
    output logic                              o_done,
    output logic                              o_illegal,
    output logic [dcv_pkg::HALF_W-1:0]        o_result,
    // Register read port for inspection
    input  wire logic                         i_rd_file_b,
    input  wire logic [dcv_pkg::REG_AW-1:0]   i_rd_idx,
    output logic [dcv_pkg::DBL_W-1:0]         o_rd_data
);
    // Each entry holds a double; singles and integers sit in the low word
    logic [dcv_pkg::DBL_W-1:0] rf_a_r [RF_DEPTH];
    logic [dcv_pkg::DBL_W-1:0] rf_b_r [RF_DEPTH];

    dcv_pkg::dcv_state_t       state_r;
    dcv_pkg::dcv_cmd_t         cmd_r;
    logic [1:0]                halves_r;
    logic                      done_r;
    logic                      illegal_r;
    logic [dcv_pkg::HALF_W-1:0] result_r;
    logic [dcv_pkg::DBL_W-1:0] rd_data_r;

    // Double to single: truncating, flushes denormals, saturates overflow to inf
    function automatic logic [31:0] dcv_to_single(input logic [63:0] d);
        logic [10:0] e;
        logic [12:0] ue;
        logic [31:0] r;
        e  = d[62:52];
        ue = {2'b00, e} - 13'(dcv_pkg::DBL_BIAS - dcv_pkg::SGL_BIAS);
        if (e == 11'h7FF) begin
            r = {d[63], 8'hFF, (d[51:0] != 52'h0), d[50:29]};
        end else if (e <= 11'(dcv_pkg::DBL_BIAS - dcv_pkg::SGL_BIAS)) begin
            r = {d[63], 31'h0};
        end else if (ue >= 13'h0FF) begin
            r = {d[63], 8'hFF, 23'h0};
        end else begin
            r = {d[63], ue[7:0], d[51:29]};
        end
        return r;
    endfunction

    // Double to integer: truncate toward zero, saturate out of range
    function automatic logic [31:0] dcv_to_int(input logic [63:0] d);
        logic [10:0] e;
        logic [10:0] sh;
        logic [84:0] m;
        logic [31:0] mag;
        logic [31:0] r;
        e  = d[62:52];
        m  = {32'h0, 1'b1, d[51:0]};
        mag = 32'h0;
        sh  = 11'h0;
        if (e < 11'(dcv_pkg::DBL_BIAS)) begin
            r = 32'h0;
        end else if (e > 11'(dcv_pkg::DBL_BIAS + 30)) begin
            r = d[63] ? 32'h80000000 : 32'h7FFFFFFF;
        end else begin
            sh  = e - 11'(dcv_pkg::DBL_BIAS);
            m   = m << sh;
            mag = m[83:52];
            r   = d[63] ? (32'h0 - mag) : mag;
        end
        return r;
    endfunction

    // Decode
    wire logic cmd_take   = i_cmd_valid & o_cmd_ready;
    wire logic src_bad    = i_cmd.src_file_b;
    wire logic needs_load = (i_cmd.src != dcv_pkg::DCV_SRC_REG);
    wire logic word_take  = i_word_valid & o_word_ready;
    wire logic last_half  = (halves_r == 2'h1);
    wire logic [dcv_pkg::DBL_W-1:0] src_val = rf_a_r[cmd_r.src_idx];
    wire logic [dcv_pkg::HALF_W-1:0] conv_val =
        (cmd_r.op == dcv_pkg::DCV_OP_TO_INTEGER) ? dcv_to_int(src_val)
                                                 : dcv_to_single(src_val);

    assign o_cmd_ready  = (state_r == dcv_pkg::DCV_ST_IDLE);
    assign o_word_ready = (state_r == dcv_pkg::DCV_ST_LOAD);
    assign o_done       = done_r;
    assign o_illegal    = illegal_r;
    assign o_result     = result_r;
    assign o_rd_data    = rd_data_r;

    // Next values of the sequencer
    dcv_pkg::dcv_state_t        state_nxt;
    dcv_pkg::dcv_cmd_t          cmd_nxt;
    logic [1:0]                 halves_nxt;
    logic                       done_nxt;
    logic                       illegal_nxt;
    logic [dcv_pkg::HALF_W-1:0] result_nxt;

    // Sequencer next state
    always_comb begin
        state_nxt   = state_r;
        cmd_nxt     = cmd_r;
        halves_nxt  = halves_r;
        done_nxt    = 1'b0;
        illegal_nxt = 1'b0;
        result_nxt  = result_r;
        case (state_r)
            dcv_pkg::DCV_ST_IDLE: begin
                // Refused command only raises illegal; command, halves count, result and files keep their values
                if (cmd_take && src_bad) begin
                    illegal_nxt = 1'b1;
                end else if (cmd_take) begin
                    cmd_nxt    = i_cmd;
                    halves_nxt = dcv_pkg::RST_HALVES;
                    state_nxt  = needs_load ? dcv_pkg::DCV_ST_LOAD : dcv_pkg::DCV_ST_CONVERT;
                end
            end
            dcv_pkg::DCV_ST_LOAD: begin
                // Only the count of halves matters; a stray early last is ignored
                if (word_take) begin
                    halves_nxt = halves_r + 2'h1;
                end
                if (word_take && last_half) begin
                    state_nxt = dcv_pkg::DCV_ST_CONVERT;
                end
            end
            dcv_pkg::DCV_ST_CONVERT: begin
                // Convert one cycle after the low half lands, so the read sees it
                result_nxt = conv_val;
                done_nxt   = 1'b1;
                state_nxt  = dcv_pkg::DCV_ST_IDLE;
            end
            default: begin
                state_nxt = dcv_pkg::DCV_ST_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state_r   <= dcv_pkg::DCV_ST_IDLE;
            cmd_r     <= '0;
            halves_r  <= dcv_pkg::RST_HALVES;
            done_r    <= 1'b0;
            illegal_r <= 1'b0;
            result_r  <= '0;
        end else begin
            state_r   <= state_nxt;
            cmd_r     <= cmd_nxt;
            halves_r  <= halves_nxt;
            done_r    <= done_nxt;
            illegal_r <= illegal_nxt;
            result_r  <= result_nxt;
        end
    end

    // Register file write enables; first word is the high half
    wire logic                      load_hi_we = word_take && (halves_r == dcv_pkg::RST_HALVES);
    wire logic                      load_lo_we = word_take && last_half;
    wire logic                      conv_we    = (state_r == dcv_pkg::DCV_ST_CONVERT);
    wire logic                      dst_a_we   = conv_we && !cmd_r.dst_file_b;
    wire logic                      dst_b_we   = conv_we && cmd_r.dst_file_b;
    wire logic [dcv_pkg::DBL_W-1:0] dst_word   = {32'h0, conv_val};

    // Files are not reset: cheaper, and software must write before reading
    // Indices past the depth are not checked; the host keeps within it
    always_ff @(posedge i_clk) begin
        if (load_hi_we) begin
            rf_a_r[cmd_r.src_idx][63:32] <= i_word.data;
        end
        if (load_lo_we) begin
            rf_a_r[cmd_r.src_idx][31:0] <= i_word.data;
        end
        // Destination write leaves the source intact unless they coincide
        if (dst_a_we) begin
            rf_a_r[cmd_r.dst_idx] <= dst_word;
        end
        if (dst_b_we) begin
            rf_b_r[cmd_r.dst_idx] <= dst_word;
        end
    end

    // Inspection read, one cycle behind the address
    wire logic [dcv_pkg::DBL_W-1:0] rd_sel = i_rd_file_b ? rf_b_r[i_rd_idx] : rf_a_r[i_rd_idx];

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rd_data_r <= '0;
        end else begin
            rd_data_r <= rd_sel;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/dcv_convert_asserts.sv
// Port checker for the double convert block
`timescale 1ns/1ps
`default_nettype none
module dcv_convert_chk (
    input wire logic                      i_clk,
    input wire logic                      i_rst_b,
    input wire logic                      i_cmd_valid,
    input wire dcv_pkg::dcv_cmd_t         i_cmd,
    input wire logic                      o_cmd_ready,
    input wire logic                      i_word_valid,
    input wire logic                      o_word_ready,
    input wire logic                      o_done,
    input wire logic                      o_illegal,
    input wire logic [dcv_pkg::HALF_W-1:0] o_result
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    wire take  = i_cmd_valid && o_cmd_ready;
    wire wtake = i_word_valid && o_word_ready;
    wire is_reg = i_cmd.src == dcv_pkg::DCV_SRC_REG;
    property p_ill; take && i_cmd.src_file_b |=> o_illegal && !o_done; endproperty
    a_ill: assert property (p_ill) else $error("file B source not refused");
    property p_reg; take && !i_cmd.src_file_b && is_reg |=> !o_cmd_ready ##1 o_done; endproperty
    a_reg: assert property (p_reg) else $error("register convert late");
    property p_load; take && !i_cmd.src_file_b && !is_reg |=> o_word_ready && !o_done; endproperty
    a_load: assert property (p_load) else $error("operand words not requested");
    property p_conv; wtake ##1 wtake |=> !o_word_ready ##1 o_done; endproperty
    a_conv: assert property (p_conv) else $error("loaded convert late");
    property p_pulse; o_done |-> o_cmd_ready ##1 !o_done; endproperty
    a_pulse: assert property (p_pulse) else $error("done not single pulse");
    property p_hold; $changed(o_result) |-> o_done; endproperty
    a_hold: assert property (p_hold) else $error("result moved without done");
    property p_ready; o_word_ready |-> !o_cmd_ready && !o_done; endproperty
    a_ready: assert property (p_ready) else $error("done before both halves");
    property p_quiet; o_illegal |-> o_cmd_ready && $stable(o_result); endproperty
    a_quiet: assert property (p_quiet) else $error("refused command changed state");
    c_reg: cover property (take && is_reg ##2 o_done);
    c_ill: cover property (o_illegal);
    c_conv: cover property (wtake ##1 wtake);
endmodule
bind dcv_convert dcv_convert_chk u_chk (.i_clk, .i_rst_b, .i_cmd_valid, .i_cmd, .o_cmd_ready,
    .i_word_valid, .o_word_ready, .o_done, .o_illegal, .o_result);
`default_nettype wire

// ===== testbench/dcv_host.sv
// Host model: sends operand halves from its registers or memory
`timescale 1ns/1ps
`default_nettype none
module dcv_host (
    input  wire logic               i_clk,
    input  wire logic               i_ready,
    output logic                    o_valid,
    output dcv_pkg::dcv_word_t      o_word
);
    logic [31:0] mem [0:7];
    logic [31:0] hreg [0:1];
    logic [31:0] ptr;
    initial begin
        o_valid = 1'b0;
        o_word = '0;
    end
    // Called 1 ns after a rising edge; returns 1 ns after the accepting edge
    task automatic put(input logic [31:0] d, input int gap);
        logic seen;
        if (gap > 0) begin
            // Released bus shows the inverse, not the last word
            o_valid = 1'b0;
            o_word.data = ~o_word.data;
            repeat (gap) @(posedge i_clk);
            #1;
        end
        o_valid = 1'b1;
        o_word = {1'b0, d};
        seen = 1'b0;
        while (!seen) begin
            @(negedge i_clk);
            seen = i_ready;
            @(posedge i_clk);
        end
        #1;
    endtask
    // Mode 0 host registers, 1 post-increment, 2 pre-decrement
    task automatic send(input int mode, input int gap);
        for (int k = 0; k < 2; k++) begin
            if (mode == 2) ptr = ptr - 32'h20;
            put(mode == 0 ? hreg[k] : mem[ptr[7:5]], gap);
            if (mode == 1) ptr = ptr + 32'h20;
        end
        o_valid = 1'b0;
        o_word.data = ~o_word.data;
    endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the double convert block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_clk = 0, i_rst_b = 0, i_cmd_valid = 0, rd_b = 0;
    logic o_cmd_ready, w_valid, o_word_ready, o_done, o_illegal;
    dcv_pkg::dcv_cmd_t  cmd = '0;
    dcv_pkg::dcv_word_t word;
    logic [31:0] o_result;
    logic [3:0]  rd_idx = 0;
    logic [63:0] o_rd_data;
    int n_mismatch = 0, n_tests = 0;
    always #2 i_clk = ~i_clk;
    dcv_convert DUT (.i_clk, .i_rst_b, .i_cmd_valid, .i_cmd(cmd), .o_cmd_ready, .i_word_valid(w_valid),
        .i_word(word), .o_word_ready, .o_done, .o_illegal, .o_result, .i_rd_file_b(rd_b), .i_rd_idx(rd_idx),
        .o_rd_data);
    dcv_host host (.i_clk, .i_ready(o_word_ready), .o_valid(w_valid), .o_word(word));
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Offer one command, feed its words, wait for done or refusal
    task automatic issue(input logic [1:0] op, src, input logic fb, input logic [3:0] s,
                         input logic [4:0] d, input int mode, gap);
        @(posedge i_clk);
        #1 i_cmd_valid = 1'b1;
        cmd = dcv_pkg::dcv_cmd_t'({op, src, fb, s, d});
        @(posedge i_clk);
        #1 i_cmd_valid = 1'b0;
        if (src != 2'h0 && !fb) host.send(mode, gap);
        repeat (12) begin
            @(negedge i_clk);
            if (o_done || o_illegal) break;
        end
        check("finished", {62'h0, o_done, o_illegal}, {62'h0, !fb, fb});
    endtask
    task automatic peek(input logic fb, input logic [3:0] idx);
        @(posedge i_clk);
        #1 rd_b = fb;
        rd_idx = idx;
        @(posedge i_clk);
        #1;
    endtask
    task automatic t_host;
        host.hreg[0] = 32'h3FF80000;
        host.hreg[1] = 32'h0;
        issue(2'h0, 2'h1, 1'b0, 4'h3, 5'h04, 0, 0);
        check("single", {32'h0, o_result}, 64'h3FC00000);
        peek(1'b0, 4'h3);
        check("source A3", o_rd_data, 64'h3FF8000000000000);
        peek(1'b0, 4'h4);
        check("dest A4", o_rd_data, 64'h3FC00000);
        host.hreg[0] = 32'hC0240000;
        issue(2'h1, 2'h1, 1'b0, 4'h2, 5'h17, 0, 0);
        peek(1'b1, 4'h7);
        check("dest B7", o_rd_data, 64'hFFFFFFF6);
        $display("host register test done");
    endtask
    task automatic t_reg;
        issue(2'h1, 2'h0, 1'b0, 4'h3, 5'h15, 0, 0);
        check("integer", {32'h0, o_result}, 64'h1);
        issue(2'h0, 2'h0, 1'b0, 4'h3, 5'h16, 0, 0);
        check("single", {32'h0, o_result}, 64'h3FC00000);
        $display("register test done");
    endtask
    task automatic t_mem;
        host.mem[0] = 32'hC0040000;
        host.mem[1] = 32'h0;
        host.ptr = 32'h0;
        issue(2'h1, 2'h2, 1'b0, 4'h6, 5'h07, 1, 1);
        check("integer", {32'h0, o_result}, 64'hFFFFFFFE);
        host.mem[1] = 32'h40090000;
        // Low half reaches the kept mantissa bits, so order shows
        issue(2'h0, 2'h2, 1'b0, 4'h8, 5'h09, 2, 1);
        check("single", {32'h0, o_result}, 64'h40480006);
        peek(1'b0, 4'h8);
        check("source A8", o_rd_data, 64'h40090000C0040000);
        $display("memory test done");
    endtask
    task automatic t_ill;
        issue(2'h0, 2'h0, 1'b1, 4'h8, 5'h0A, 0, 0);
        check("illegal", {63'h0, o_illegal}, 64'h1);
        check("kept result", {32'h0, o_result}, 64'h40480006);
        $display("refusal test done");
    endtask
    initial begin
        repeat (12) @(posedge i_clk);
        #1 i_rst_b = 1'b1;
        t_host();
        t_reg();
        t_mem();
        t_ill();
        final_report();
    end
    initial begin
        #20000;
        n_mismatch++;
        final_report();
    end
endmodule
`default_nettype wire
